/* File: arf_format.v */
`timescale 1ns/1ps
`include "arf_regs.vh"
module arf_format
(
  input  wire [9:0] conversion_result,
  input  wire       justification_select,
  output reg  [7:0] high_d,
  output reg  [7:0] low_d
);
  always @*
  begin
    if (justification_select)
    begin
      high_d = {6'h00, conversion_result[9:8]};
      low_d  = conversion_result[7:0];
    end
    else
    begin
      high_d = conversion_result[9:2];
      low_d  = {conversion_result[1:0], 6'h00};
    end
  end
endmodule

/* File: arf_regs.vh */
`ifndef ARF_REGS_VH
`define ARF_REGS_VH
// Register indices on the plain register port
`define ARF_ADDR_W          3
`define ARF_OFF_CHAN_CTRL   3'h0
`define ARF_OFF_CLK_FMT     3'h1
`define ARF_OFF_TRIG_SEL    3'h2
`define ARF_OFF_RESULT_HIGH 3'h3
`define ARF_OFF_RESULT_LOW  3'h4
`define ARF_OFF_STATUS      3'h5
// Field positions
`define ARF_FMT_JUST_BIT    7
`define ARF_CHAN_ON_BIT     0
`define ARF_CHAN_GO_BIT     1
`define ARF_CHAN_SEL_HI     6
`define ARF_CHAN_SEL_LO     2
`define ARF_STAT_ACQ_BIT    0
`define ARF_STAT_BUSY_BIT   1
// Reset values and write masks
`define ARF_CHAN_CTRL_RST   8'h00
`define ARF_CLK_FMT_RST     8'h00
`define ARF_TRIG_SEL_RST    8'h00
`define ARF_CLK_FMT_MASK    8'hf3
`define ARF_TRIG_SEL_MASK   8'hf8
`define ARF_CHAN_CTRL_MASK  8'h7f
// Timing: acquisition interval in ns, clock period in ns and conversion length in clock cycles
`define ARF_TACQ_NS         4370
`define ARF_CLK_NS          20
`define ARF_CONV_CYCLES     12
`endif

/* File: arf_sync.v */
`timescale 1ns/1ps
module arf_sync
(
  input  wire clk,
  input  wire rst_n,
  input  wire d,
  output wire q
);
  reg meta_q;
  reg sync_q;
  // Second stage is the only reader of the first
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end
  assign q = sync_q;
endmodule

/* File: arf_top.v */
// Decided for this implementation: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`include "arf_regs.vh"
// Summary of operation
// - Left format: result 9..2 in high
// - Left format: result 1..0 in low 7..6
// - Right format: result 9..8 in high 1..0
// - Right format: result 7..0 in low
// - Results read/write, kept over warm resets
// - Hold capacitor never discharged after conversion
module arf_top
#(
  parameter CONV_CYCLES = `ARF_CONV_CYCLES
)
(
  input  wire                   clk,
  input  wire                   reset_n,
  input  wire                   por_n,
  input  wire [`ARF_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output wire [7:0]             reg_rdata,
  input  wire [9:0]             conv_sample,
  input  wire                   conv_sample_valid,
  output wire                   conv_start,
  output wire                   adc_enable,
  output wire [4:0]             channel_select,
  output wire                   sample_hold_discharge
);
  localparam ACQ_CYCLES_I = (`ARF_TACQ_NS + `ARF_CLK_NS - 1) / `ARF_CLK_NS;
  localparam [7:0] ACQ_CYCLES = ACQ_CYCLES_I[7:0];
  localparam [7:0] CONV_LEN   = CONV_CYCLES[7:0];
  localparam ST_IDLE = 2'h0;
  localparam ST_ACQ  = 2'h1;
  localparam ST_CONV = 2'h2;

  wire       rst_n;
  wire       por_s_n;
  wire       valid_s;
  reg  [1:0] rst_pipe_q;
  reg  [1:0] por_pipe_q;
  reg  [7:0] chan_q;
  reg  [7:0] fmt_q;
  reg  [7:0] trig_q;
  reg  [7:0] high_q;
  reg  [7:0] low_q;
  reg  [7:0] rdata_q;
  reg  [7:0] rdata_d;
  reg  [1:0] state_q;
  reg  [7:0] cnt_q;
  reg        acq_done_q;
  reg  [9:0] sample_q;
  reg        start_q;
  wire [7:0] high_d;
  wire [7:0] low_d;
  wire       wr_chan;
  wire       conv_done;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rst_pipe_q <= 2'b00;
    else
      rst_pipe_q <= {rst_pipe_q[0], 1'b1};
  end
  assign rst_n = rst_pipe_q[1];

  // Power-on reset also leaves through two stages so its release never races the clock
  always @(posedge clk or negedge por_n)
  begin
    if (!por_n)
      por_pipe_q <= 2'b00;
    else
      por_pipe_q <= {por_pipe_q[0], 1'b1};
  end
  assign por_s_n = por_pipe_q[1];

  // Converter data comes from the analog domain
  arf_sync u_valid_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (conv_sample_valid),
    .q     (valid_s)
  );

  arf_format u_format
  (
    .conversion_result    (sample_q),
    .justification_select (fmt_q[`ARF_FMT_JUST_BIT]),
    .high_d               (high_d),
    .low_d                (low_d)
  );

  assign wr_chan   = reg_wr && (reg_addr == `ARF_OFF_CHAN_CTRL);
  assign conv_done = (state_q == ST_CONV) && (cnt_q == 8'h00);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chan_q     <= `ARF_CHAN_CTRL_RST;
      fmt_q      <= `ARF_CLK_FMT_RST;
      trig_q     <= `ARF_TRIG_SEL_RST;
      rdata_q    <= 8'h00;
      state_q    <= ST_IDLE;
      cnt_q      <= 8'h00;
      acq_done_q <= 1'b0;
      start_q    <= 1'b0;
      sample_q   <= 10'h000;
    end
    else
    begin
      rdata_q <= reg_rd ? rdata_d : 8'h00;
      start_q <= 1'b0;
      if (valid_s)
        sample_q <= conv_sample;
      if (reg_wr && reg_addr == `ARF_OFF_CLK_FMT)
        fmt_q <= reg_wdata & `ARF_CLK_FMT_MASK;
      if (reg_wr && reg_addr == `ARF_OFF_TRIG_SEL)
        trig_q <= reg_wdata & `ARF_TRIG_SEL_MASK;
      if (wr_chan)
        chan_q <= reg_wdata & `ARF_CHAN_CTRL_MASK;
      // Channel change restarts the acquisition timer
      if (wr_chan && reg_wdata[`ARF_CHAN_SEL_HI:`ARF_CHAN_SEL_LO] !=
          chan_q[`ARF_CHAN_SEL_HI:`ARF_CHAN_SEL_LO])
      begin
        acq_done_q <= 1'b0;
        state_q    <= ST_ACQ;
        cnt_q      <= ACQ_CYCLES;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            if (wr_chan && reg_wdata[`ARF_CHAN_GO_BIT] && reg_wdata[`ARF_CHAN_ON_BIT])
            begin
              // Start is honoured only after acquisition; early starts go to ST_ACQ and convert when the timer ends
              if (acq_done_q)
              begin
                state_q <= ST_CONV;
                cnt_q   <= CONV_LEN;
                start_q <= 1'b1;
              end
              else
              begin
                state_q <= ST_ACQ;
                cnt_q   <= ACQ_CYCLES;
              end
            end
          end
          ST_ACQ:
          begin
            if (cnt_q == 8'h00)
            begin
              acq_done_q <= 1'b1;
              if (chan_q[`ARF_CHAN_GO_BIT])
              begin
                state_q <= ST_CONV;
                cnt_q   <= CONV_LEN;
                start_q <= 1'b1;
              end
              else
                state_q <= ST_IDLE;
            end
            else
              cnt_q <= cnt_q - 8'h01;
          end
          ST_CONV:
          begin
            if (cnt_q == 8'h00)
            begin
              state_q <= ST_IDLE;
              chan_q[`ARF_CHAN_GO_BIT] <= 1'b0;
            end
            else
              cnt_q <= cnt_q - 8'h01;
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Results reset only on power-on/brown-out, and then to an arbitrary zero
  always @(posedge clk or negedge por_s_n)
  begin
    if (!por_s_n)
    begin
      high_q <= 8'h00;
      low_q  <= 8'h00;
    end
    else if (conv_done)
    begin
      high_q <= high_d;
      low_q  <= low_d;
    end
    else
    begin
      if (reg_wr && reg_addr == `ARF_OFF_RESULT_HIGH)
        high_q <= reg_wdata;
      if (reg_wr && reg_addr == `ARF_OFF_RESULT_LOW)
        low_q <= reg_wdata;
    end
  end

  always @*
  begin
    case (reg_addr)
      `ARF_OFF_CHAN_CTRL:   rdata_d = chan_q;
      `ARF_OFF_CLK_FMT:     rdata_d = fmt_q;
      `ARF_OFF_TRIG_SEL:    rdata_d = trig_q;
      `ARF_OFF_RESULT_HIGH: rdata_d = high_q;
      `ARF_OFF_RESULT_LOW:  rdata_d = low_q;
      `ARF_OFF_STATUS:      rdata_d = {6'h00, state_q != ST_IDLE, acq_done_q};
      default:              rdata_d = 8'h00;
    endcase
  end

  assign reg_rdata             = rdata_q;
  assign conv_start            = start_q;
  assign adc_enable            = chan_q[`ARF_CHAN_ON_BIT];
  assign channel_select        = chan_q[`ARF_CHAN_SEL_HI:`ARF_CHAN_SEL_LO];
  assign sample_hold_discharge = 1'b0;
endmodule

/* File: arf_top_props.sv */
`timescale 1ns/1ps
module arf_top_props
#(
  parameter CONV_CYCLES = 12
)
(
  input wire       clk,
  input wire       reset_n,
  input wire       por_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire [9:0] conv_sample,
  input wire       conv_start,
  input wire       adc_enable,
  input wire       sample_hold_discharge
);
  reg  [7:0] age_q;
  reg        fmt_q;
  // Results are judged once the completion write has landed; ff means no conversion yet
  wire       done = age_q >= CONV_CYCLES && age_q != 8'hff;
  wire       rd_hi = reg_rd && reg_addr == 3'h3 && done;
  wire       rd_lo = reg_rd && reg_addr == 3'h4 && done;
  always @(posedge clk or negedge reset_n)
    if (!reset_n)
    begin
      age_q <= 8'hff;
      fmt_q <= 1'b0;
    end
    else
    begin
      if (conv_start)
        age_q <= 8'h00;
      else if (age_q < 8'hfe)
        age_q <= age_q + 8'h01;
      if (reg_wr && reg_addr == 3'h1)
        fmt_q <= reg_wdata[7];
    end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n || !por_n);
  sequence s_wr_rd_high;
    reg_wr && reg_addr == 3'h3 && !adc_enable ##1 reg_rd && reg_addr == 3'h3;
  endsequence
  a_left_high: assert property (
    rd_hi && !fmt_q |=> reg_rdata == conv_sample[9:2]) else $error("left high wrong");
  a_left_low: assert property (
    rd_lo && !fmt_q |=> reg_rdata == {conv_sample[1:0], 6'h00}) else $error("left low wrong");
  a_right_high: assert property (
    rd_hi && fmt_q |=> reg_rdata == {6'h00, conv_sample[9:8]}) else $error("right high wrong");
  a_right_low: assert property (
    rd_lo && fmt_q |=> reg_rdata == conv_sample[7:0]) else $error("right low wrong");
  a_no_discharge: assert property (
    !sample_hold_discharge) else $error("hold discharged");
  a_write_kept: assert property (
    s_wr_rd_high |=> reg_rdata == $past(reg_wdata, 2)) else $error("result write lost");
  a_read_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data without read");
endmodule

bind arf_top arf_top_props #(.CONV_CYCLES(CONV_CYCLES)) arf_top_props_inst (
  .clk(clk), .reset_n(reset_n), .por_n(por_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .conv_sample(conv_sample), .conv_start(conv_start), .adc_enable(adc_enable),
  .sample_hold_discharge(sample_hold_discharge)
);

/* File: arf_top_tb_top.sv */
`timescale 1ns/1ps
module arf_top_tb_top;
  reg        clk = 1'b0;
  reg        reset_n = 1'b0;
  reg        por_n = 1'b0;
  reg  [2:0] reg_addr = 3'h0;
  reg  [7:0] reg_wdata = 8'h00;
  reg        reg_wr = 1'b0;
  reg        reg_rd = 1'b0;
  reg  [9:0] conv_sample = 10'h000;
  reg        conv_sample_valid = 1'b0;
  wire [7:0] reg_rdata;
  integer    n_errors = 0;
  integer    tests_run = 0;
  integer    i;
  reg  [7:0] rv;
  // Short conversion keeps the run brief; checks do not depend on its length
  arf_top #(.CONV_CYCLES(2)) arf_top_inst (
    .clk(clk), .reset_n(reset_n), .por_n(por_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv_sample(conv_sample), .conv_sample_valid(conv_sample_valid), .conv_start(),
    .adc_enable(), .channel_select(), .sample_hold_discharge()
  );
  initial
  begin
    forever #10 clk = ~clk;
  end
  task summarize;
  begin
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end
  endtask
  task chk(input string nm, input [7:0] ex);
  begin
    tests_run = tests_run + 1;
    if (rv !== ex)
    begin
      n_errors = n_errors + 1;
      $display("ERROR %s expected %h seen %h", nm, ex, rv);
    end
  end
  endtask
  task wr(input [2:0] a, input [7:0] d);
  begin
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  end
  endtask
  task rd(input [2:0] a);
  begin
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  end
  endtask
  task wrrd(input [2:0] a, input [7:0] d);
  begin
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rv = reg_rdata;
  end
  endtask
  task conv(input f, input [9:0] s);
  begin
    @(posedge clk);
    conv_sample <= s;
    wr(3'h1, {f, 7'h00});
    wr(3'h0, 8'h03);
    rv = 8'h02;
    for (i = 0; i < 200 && rv[1]; i = i + 1)
      rd(3'h0);
    if (rv[1])
    begin
      n_errors = n_errors + 1;
      summarize;
    end
    rd(3'h3);
    chk("high", f ? {6'h00, s[9:8]} : s[9:2]);
    rd(3'h4);
    chk("low", f ? s[7:0] : {s[1:0], 6'h00});
  end
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    por_n <= 1'b1;
    conv_sample_valid <= 1'b1;
    repeat (3) @(posedge clk);
    wr(3'h3, 8'ha5);
    rd(3'h3);
    chk("high", 8'ha5);
    wr(3'h4, 8'h5a);
    rd(3'h4);
    chk("low", 8'h5a);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(3'h3);
    chk("kept", 8'ha5);
    wrrd(3'h3, 8'h3c);
    chk("high b2b", 8'h3c);
    conv(1'b0, 10'h3ff);
    conv(1'b1, 10'h3ff);
    conv(1'b0, 10'h201);
    conv(1'b1, 10'h17e);
    summarize;
  end
endmodule
